/* core/crb_map.svh */
// Offsets, field positions, reset values and limits of the builder
`ifndef CRB_MAP_SVH
`define CRB_MAP_SVH

// ----------------------------------------
// Packet identity
// ----------------------------------------
`define CRB_RESP_TYPE   8'h96

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CRB_OFS_STATUS  8'h00
`define CRB_OFS_FLAGS   8'h04
`define CRB_OFS_BCAST   8'h08
`define CRB_OFS_MCAST   8'h0c
`define CRB_OFS_BUFCAP  8'h10
`define CRB_OFS_EVENTS  8'h14
`define CRB_OFS_COUNTS  8'h18
`define CRB_OFS_VMODE   8'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CRB_ST_BUSY     0
`define CRB_ST_LIMERR   1
`define CRB_ST_SENT     2
`define CRB_FLAGS_W     7
`define CRB_ARB_HI      6
`define CRB_ARB_LO      5
`define CRB_ARB_RSVD    2'h3
`define CRB_ARB_UNKNOWN 2'h0
`define CRB_VMODE_W     3
`define CRB_VMODE_SEL   10:9
`define CRB_VMODE_POS   8

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CRB_RST_UC      8'h01
`define CRB_RST_VMODE   8'h01
`define CRB_VLAN_MAX    8'h0f
`define CRB_FILT_MAX    10'h008
`define CRB_LAST_WORD   4'h8
`define CRB_LAST_BYTE   2'h3

`endif

/* core/crb_pkg.sv */
// Types shared by the capabilities response builder
`default_nettype none
package crb_pkg;

	// Frame sequencer states
	typedef enum logic [0:0] {CRB_IDLE, CRB_SEND} crb_state_t;

	// Eight payload words ahead of the checksum
	typedef logic [7:0][31:0] crb_words_t;

	// Whole state of the main module
	typedef struct packed {
		crb_state_t  state;
		logic [3:0]  widx;
		logic [1:0]  bidx;
		logic        tx_valid;
		logic        tx_last;
		logic [7:0]  tx_byte;
		logic [7:0]  resp_type;
		crb_words_t  frame;
		logic [6:0]  flags;
		logic [31:0] bcast;
		logic [31:0] mcast;
		logic [31:0] bufcap;
		logic [31:0] events;
		logic [7:0]  vlan;
		logic [7:0]  mix;
		logic [7:0]  mc;
		logic [7:0]  uc;
		logic [7:0]  vmode;
		logic [7:0]  chan;
		logic        lim_err;
		logic        sent;
		logic [31:0] rdata;
	} crb_main_st_t;

	// Whole state of the checksum unit
	typedef struct packed {
		logic [31:0] csum;
	} crb_csum_st_t;

endpackage : crb_pkg
`default_nettype wire

/* core/crb_csum_if.sv */
// Link between the frame sequencer and the checksum unit
`timescale 1ns/10ps
`default_nettype none
interface crb_csum_if;
	import crb_pkg::*;
	logic        load;  // Snapshot strobe
	logic [31:0] seed;  // Header partial sum
	crb_words_t  words; // Payload words
	logic [31:0] csum;  // Registered checksum

	modport seq  (output load, seed, words, input csum);
	modport calc (input load, seed, words, output csum);
endinterface : crb_csum_if
`default_nettype wire

/* core/crb_csum.sv */
// Checksum unit: two's complement of the 16-bit word sum
`timescale 1ns/10ps
`default_nettype none
module crb_csum
	import crb_pkg::*;
(
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_reset_n,
	// Sequencer side
	crb_csum_if.calc  cs
);

	crb_csum_st_t s_q; // Registered state
	crb_csum_st_t s_d; // Next state

	// --------------------------------------
	// Sum of halves, taken on the snapshot
	// --------------------------------------
	// Done in one cycle: the sequencer needs the
	// value only after 32 bytes have left
	always_comb
	begin
		logic [31:0] sum;
		sum = cs.seed;
		s_d = s_q;
		for (int i = 0; i < 8; i++)
		begin
			sum = sum + {16'h0000, cs.words[i][31:16]};
			sum = sum + {16'h0000, cs.words[i][15:0]};
		end
		if (cs.load)
			s_d.csum = 32'h0000_0000 - sum;
	end

	// State register
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign cs.csum = s_q.csum;

endmodule : crb_csum
`default_nettype wire

/* core/crb_top.sv */
// Capabilities response builder: config registers and byte framer
//
// Overview of operation
// RULE1 - Accept clean request, send type 0x96 response
// RULE2 - Reason code taken from generic response set
// RULE3 - Flag bit 0 reports hardware arbitration support
// RULE4 - Flag bit 1 reports driver status support
// RULE5 - Flag bits 2,3 report both flow controls
// RULE6 - Flag bit 4 reports all-multicast support
// RULE7 - Bits 6..5 arbitration state; 31..7 zero
// RULE8 - Broadcast word mirrors supported filter bits
// RULE9 - Multicast word mirrors supported filter bits
// RULE10 - Buffering word gives bytes, zero unspecified
// RULE11 - Event word uses notice control layout
// RULE12 - VLAN filter count never above fifteen
// RULE13 - Separate unicast, multicast, mixed filter counts
// RULE14 - At least one unicast or mixed filter
// RULE15 - Total of filter counts at most eight
// RULE16 - VLAN mode bit 0 always one
// RULE17 - Mode bits 1,2 reported, bits 7..3 zero
// RULE18 - Channel count byte reports package channels
// RULE19 - Fields emitted in fixed order, big endian
// RULE20 - Trailing checksum over assembled response appended
//
// Our own choices: the plain strobed port and the register offsets.
`include "crb_map.svh"
`timescale 1ns/10ps
`default_nettype none
module crb_top
	import crb_pkg::*;
(
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset_n,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	output var  logic [31:0] o_rdata,
	// Request from the command decoder
	input  wire logic        i_req_valid,
	input  wire logic [15:0] i_resp_code,
	input  wire logic [15:0] i_reason_code,
	input  wire logic [31:0] i_csum_seed,
	output var  logic        o_req_ready,
	// Response byte stream
	output var  logic        o_tx_valid,
	output var  logic [7:0]  o_tx_data,
	output var  logic        o_tx_last,
	output var  logic [7:0]  o_resp_type,
	input  wire logic        i_tx_ready
);

	crb_main_st_t q;         // Registered state
	crb_main_st_t d;         // Next state
	crb_words_t   cfg_words; // Live payload image
	logic         accept;    // Request taken
	logic         advance;   // Byte taken
	logic [3:0]   nw;        // Next word index
	logic [1:0]   nb;        // Next byte index

	crb_csum_if csum_if (); // Checksum link

	// --------------------------------------
	// Helpers
	// --------------------------------------

	// Big endian byte pick, most significant first
	function automatic logic [7:0] byte_of(
		input logic [31:0] w,
		input logic [1:0]  b
	);
		case (b)
			2'h0:    byte_of = w[31:24];
			2'h1:    byte_of = w[23:16];
			2'h2:    byte_of = w[15:8];
			default: byte_of = w[7:0];
		endcase
	endfunction : byte_of

	// Filter count limits, checked before storing
	function automatic logic counts_ok(
		input logic [31:0] w
	);
		logic [9:0] total;
		logic [9:0] unis;
		total = {2'h0, w[23:16]} + {2'h0, w[15:8]}
			+ {2'h0, w[7:0]};
		unis = {2'h0, w[23:16]} + {2'h0, w[7:0]};
		counts_ok = (w[31:24] <= `CRB_VLAN_MAX)
			&& (unis != 10'h000)
			&& (total <= `CRB_FILT_MAX);
	endfunction : counts_ok

	// --------------------------------------
	// Payload image
	// --------------------------------------
	// Word order is fixed by the packet layout
	always_comb
	begin
		cfg_words[0] = {i_resp_code, i_reason_code}; // RULE2
		cfg_words[1] = {25'h0000000, q.flags}; // RULE4 RULE5 RULE6 RULE7
		cfg_words[2] = q.bcast;                      // RULE8
		cfg_words[3] = q.mcast;                      // RULE9
		cfg_words[4] = q.bufcap;                     // RULE10
		cfg_words[5] = q.events;                     // RULE11
		cfg_words[6] = {q.vlan, q.mix, q.mc, q.uc};  // RULE19
		cfg_words[7] = {16'h0000, q.vmode, q.chan};  // RULE18
	end

	// Checksum sees the same snapshot as the frame
	assign csum_if.load  = accept;
	assign csum_if.seed  = i_csum_seed;
	assign csum_if.words = cfg_words;

	crb_csum u_csum (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.cs        (csum_if)
	);

	// --------------------------------------
	// Handshakes and byte walk
	// --------------------------------------
	assign accept  = (q.state == CRB_IDLE) && i_req_valid;
	assign advance = (q.state == CRB_SEND) && i_tx_ready;
	assign nb      = q.bidx + 2'h1;
	assign nw      = (q.bidx == `CRB_LAST_BYTE)
		? q.widx + 4'h1 : q.widx;

	// --------------------------------------
	// Next state
	// --------------------------------------
	always_comb
	begin
		d = q;
		d.rdata = 32'h0000_0000;

		// Framer
		if (accept)
		begin
			// Snapshot keeps later writes out of the frame
			d.frame     = cfg_words;
			d.state     = CRB_SEND;
			d.widx      = 4'h0;
			d.bidx      = 2'h0;
			d.tx_valid  = 1'b1;
			d.tx_last   = 1'b0;
			d.tx_byte   = i_resp_code[15:8];  // RULE19
			d.resp_type = `CRB_RESP_TYPE;     // RULE1
		end
		else if (advance && q.tx_last)
		begin
			// Frame over, back to waiting
			d.state    = CRB_IDLE;
			d.tx_valid = 1'b0;
			d.tx_last  = 1'b0;
		end
		else if (advance)
		begin
			d.widx = nw;
			d.bidx = nb;
			if (nw == `CRB_LAST_WORD)
				d.tx_byte = byte_of(csum_if.csum, nb); // RULE20
			else
				d.tx_byte = byte_of(q.frame[nw[2:0]], nb); // RULE19
			d.tx_last = (nw == `CRB_LAST_WORD)
				&& (nb == `CRB_LAST_BYTE);
		end

		// Register writes
		if (i_wr_en)
		begin
			case (i_addr)
				`CRB_OFS_STATUS:
				begin
					// Write one to clear
					if (i_wdata[`CRB_ST_LIMERR])
						d.lim_err = 1'b0;
					if (i_wdata[`CRB_ST_SENT])
						d.sent = 1'b0;
				end
				`CRB_OFS_FLAGS:
				begin
					d.flags = i_wdata[`CRB_FLAGS_W-1:0]; // RULE3
					// Reserved state code reads unknown
					if (i_wdata[`CRB_ARB_HI:`CRB_ARB_LO]
						== `CRB_ARB_RSVD)
						d.flags[`CRB_ARB_HI:`CRB_ARB_LO] =
							`CRB_ARB_UNKNOWN; // RULE7
				end
				`CRB_OFS_BCAST:  d.bcast  = i_wdata; // RULE8
				`CRB_OFS_MCAST:  d.mcast  = i_wdata; // RULE9
				`CRB_OFS_BUFCAP: d.bufcap = i_wdata; // RULE10
				`CRB_OFS_EVENTS: d.events = i_wdata; // RULE11
				`CRB_OFS_COUNTS:
				begin
					// Whole word refused when a limit breaks
					if (counts_ok(i_wdata))
					begin
						d.vlan = i_wdata[31:24]; // RULE12
						d.mix  = i_wdata[23:16]; // RULE13
						d.mc   = i_wdata[15:8];  // RULE13
						d.uc   = i_wdata[7:0];   // RULE13
					end
					else
						d.lim_err = 1'b1;        // RULE15
				end
				`CRB_OFS_VMODE:
				begin
					// Bit 0 forced, upper bits held zero
					d.vmode = {5'h00,
						i_wdata[`CRB_VMODE_SEL],
						1'b1}; // RULE16 RULE17
					d.chan  = i_wdata[7:0];    // RULE18
				end
				default: ;
			endcase
		end

		// Set wins over a clear in the same cycle
		if (advance && q.tx_last)
			d.sent = 1'b1;

		// Register reads, data valid next cycle
		if (i_rd_en)
		begin
			case (i_addr)
				`CRB_OFS_STATUS:
				begin
					d.rdata[`CRB_ST_BUSY]   = q.state == CRB_SEND;
					d.rdata[`CRB_ST_LIMERR] = q.lim_err;
					d.rdata[`CRB_ST_SENT]   = q.sent;
				end
				`CRB_OFS_FLAGS:  d.rdata = cfg_words[1];
				`CRB_OFS_BCAST:  d.rdata = q.bcast;
				`CRB_OFS_MCAST:  d.rdata = q.mcast;
				`CRB_OFS_BUFCAP: d.rdata = q.bufcap;
				`CRB_OFS_EVENTS: d.rdata = q.events;
				`CRB_OFS_COUNTS: d.rdata = cfg_words[6];
				`CRB_OFS_VMODE:
					d.rdata = {16'h0000, q.vmode, q.chan};
				// Unmapped offsets read zero
				default: d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// --------------------------------------
	// State register
	// --------------------------------------
	// One filter and VLAN-only mode from reset,
	// so the limits hold before any write
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			q       <= '0;
			q.uc    <= `CRB_RST_UC;    // RULE14
			q.vmode <= `CRB_RST_VMODE; // RULE16
		end
		else
			q <= d;
	end

	// --------------------------------------
	// Outputs
	// --------------------------------------
	assign o_req_ready = q.state == CRB_IDLE;
	assign o_tx_valid  = q.tx_valid;
	assign o_tx_data   = q.tx_byte;
	assign o_tx_last   = q.tx_last;
	assign o_resp_type = q.resp_type;
	assign o_rdata     = q.rdata;

	// --------------------------------------
	// Assertions
	// --------------------------------------
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);

	// Request taken
	sequence s_accept;
		q.state == CRB_IDLE && i_req_valid;
	endsequence

	// First byte on the stream
	sequence s_first;
		o_tx_valid && !o_tx_last
			&& o_resp_type == `CRB_RESP_TYPE;
	endsequence

	// Closing byte taken
	sequence s_close;
		o_tx_valid && o_tx_last && i_tx_ready;
	endsequence

	property p_accept;
		s_accept |=> s_first
			and (o_tx_data == $past(i_resp_code[15:8]));
	endproperty
	a_accept: assert property (p_accept) // RULE1
		else $error("response did not start");

	property p_reason;
		s_accept |=> q.frame[0] ==
			{$past(i_resp_code), $past(i_reason_code)};
	endproperty
	a_reason: assert property (p_reason) // RULE2
		else $error("code word not captured");

	property p_flags;
		i_wr_en && i_addr == `CRB_OFS_FLAGS
			&& i_wdata[`CRB_ARB_HI:`CRB_ARB_LO] != `CRB_ARB_RSVD
			|=> q.flags == $past(i_wdata[`CRB_FLAGS_W-1:0]);
	endproperty
	a_flags: assert property (p_flags) // RULE3
		else $error("flag write lost");

	property p_arb;
		q.flags[`CRB_ARB_HI:`CRB_ARB_LO] != `CRB_ARB_RSVD
			&& cfg_words[1][31:`CRB_FLAGS_W] == 25'h0000000;
	endproperty
	a_arb: assert property (p_arb) // RULE7
		else $error("reserved flag state seen");

	property p_vlan;
		q.vlan <= `CRB_VLAN_MAX;
	endproperty
	a_vlan: assert property (p_vlan) // RULE12
		else $error("vlan count above limit");

	property p_unicast;
		q.uc != 8'h00 || q.mix != 8'h00;
	endproperty
	a_unicast: assert property (p_unicast) // RULE14
		else $error("no unicast capable filter");

	property p_refuse;
		i_wr_en && i_addr == `CRB_OFS_COUNTS
			&& !counts_ok(i_wdata)
			|=> q.lim_err && $stable(cfg_words[6]);
	endproperty
	a_refuse: assert property (p_refuse) // RULE15
		else $error("bad counts stored");

	property p_vmode;
		q.vmode[0] && q.vmode[7:`CRB_VMODE_W] == 5'h00;
	endproperty
	a_vmode: assert property (p_vmode) // RULE16
		else $error("vlan mode bits wrong");

	property p_last;
		o_tx_valid && o_tx_last |->
			q.widx == `CRB_LAST_WORD
			&& q.bidx == `CRB_LAST_BYTE;
	endproperty
	a_last: assert property (p_last) // RULE19
		else $error("frame closed at wrong byte");

	property p_csum;
		o_tx_valid && q.widx == `CRB_LAST_WORD
			|-> o_tx_data == byte_of(csum_if.csum, q.bidx);
	endproperty
	a_csum: assert property (p_csum) // RULE20
		else $error("checksum byte wrong");

	property p_close;
		s_close |=> !o_tx_valid && q.sent
			&& o_req_ready;
	endproperty
	a_close: assert property (p_close) // RULE1
		else $error("frame end not recorded");

endmodule : crb_top
`default_nettype wire

/* verification/crb_sink.sv */
// Byte sink standing in for the management controller side
`timescale 1ns/10ps
`default_nettype none
module crb_sink
(
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset_n,
	// Bench control
	input  wire logic       i_slow,
	input  wire logic       i_clear,
	// Response byte stream
	input  wire logic       i_valid,
	input  wire logic [7:0] i_data,
	input  wire logic       i_last,
	output var  logic       o_ready,
	// Captured frame
	output var  logic [7:0] o_bytes [36],
	output var  logic [5:0] o_count,
	output var  logic [5:0] o_last_at,
	output var  logic [1:0] o_last_cnt
);
	// ----------------------------------------
	// Capture
	// ----------------------------------------
	// Slow mode stalls every other cycle, so held bytes get tested
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_ready    <= 1'b0;
			o_count    <= 6'h00;
			o_last_at  <= 6'h00;
			o_last_cnt <= 2'h0;
		end
		else if (i_clear)
		begin
			// Fresh frame
			o_ready    <= 1'b1;
			o_count    <= 6'h00;
			o_last_cnt <= 2'h0;
		end
		else
		begin
			o_ready <= i_slow ? ~o_ready : 1'b1;
			if (i_valid && o_ready && o_count < 6'h24)
			begin
				o_bytes[o_count] <= i_data;
				o_count          <= o_count + 6'h01;
				if (i_last)
				begin
					o_last_at  <= o_count;
					o_last_cnt <= o_last_cnt + 2'h1;
				end
			end
		end
	end
endmodule : crb_sink
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench of the capabilities response builder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        i_ref_clk, i_reset_n, i_wr_en, i_rd_en;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, i_csum_seed;
	logic        i_req_valid, o_req_ready, i_tx_ready;
	logic [15:0] i_resp_code, i_reason_code;
	logic        o_tx_valid, o_tx_last, sink_slow, sink_clear;
	logic [7:0]  o_tx_data, o_resp_type;
	logic [7:0]  cap_bytes [36];
	logic [5:0]  cap_count, cap_last_at;
	logic [1:0]  cap_last_cnt;
	int          n_fail, cmp_count;
	logic [31:0] ew [9];  // Expected frame words
	logic [31:0] rdv;
	// Register rows: write flag, address, data, read-back value
	typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;} crb_row_t;
	crb_row_t rows [20] = '{
		'{0, 8'h04, 0, 0}, '{0, 8'h18, 0, 32'h1},
		'{0, 8'h1c, 0, 32'h100}, '{0, 8'h00, 0, 0},
		'{1, 8'h04, 32'hffffffff, 32'h1f}, '{1, 8'h04, 32'h5f, 32'h5f},
		'{1, 8'h08, 32'ha5a5a5a5, 32'ha5a5a5a5}, '{1, 8'h0c, 32'hf3, 32'hf3},
		'{1, 8'h10, 32'h1000, 32'h1000}, '{1, 8'h14, 32'h7, 32'h7},
		'{1, 8'h18, 32'h0f020303, 32'h0f020303},
		'{1, 8'h18, 32'h10000001, 32'h0f020303},
		'{1, 8'h18, 32'h00030303, 32'h0f020303},
		'{1, 8'h18, 32'h00000400, 32'h0f020303},
		'{1, 8'h1c, 32'h604, 32'h704}, '{1, 8'h1c, 32'hfffff9ff, 32'h1ff},
		'{1, 8'h1c, 32'h202, 32'h302}, '{1, 8'h40, 32'h12345678, 0},
		'{0, 8'h00, 0, 32'h2}, '{1, 8'h00, 32'h2, 0}};
	// Configuration left behind by the rows, in frame order
	logic [31:0] cfg [1:7] = '{32'h5f, 32'ha5a5a5a5, 32'hf3, 32'h1000,
		32'h7, 32'h0f020303, 32'h302};

	// ----------------------------------------
	// Instances
	// ----------------------------------------
	crb_top dut_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en), .o_rdata(o_rdata), .i_req_valid(i_req_valid),
		.i_resp_code(i_resp_code), .i_reason_code(i_reason_code),
		.i_csum_seed(i_csum_seed), .o_req_ready(o_req_ready),
		.o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
		.o_tx_last(o_tx_last), .o_resp_type(o_resp_type),
		.i_tx_ready(i_tx_ready));
	crb_sink sink_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
		.i_slow(sink_slow), .i_clear(sink_clear), .i_valid(o_tx_valid),
		.i_data(o_tx_data), .i_last(o_tx_last), .o_ready(i_tx_ready),
		.o_bytes(cap_bytes), .o_count(cap_count),
		.o_last_at(cap_last_at), .o_last_cnt(cap_last_cnt));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : check

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr_en <= 1'b1;
		@(posedge i_ref_clk);
		i_wr_en <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		i_addr  <= a;
		i_rd_en <= 1'b1;
		@(posedge i_ref_clk);
		i_rd_en <= 1'b0;
		#1 d = o_rdata;
	endtask : rd

	// Request one frame and compare all 36 bytes
	task automatic frame(input logic slow, input logic midwr,
		input logic [15:0] rc, input logic [15:0] rs, input logic [31:0] sd);
		logic [31:0] sum;
		int          k;
		ew[0] = {rc, rs};
		sum   = sd;
		for (k = 1; k < 8; k++)
			ew[k] = cfg[k];
		for (k = 0; k < 8; k++)
			sum = sum + ew[k][31:16] + ew[k][15:0];
		ew[8] = 32'h0 - sum;
		@(posedge i_ref_clk);
		sink_slow     <= slow;
		sink_clear    <= 1'b1;
		i_req_valid   <= 1'b1;
		i_resp_code   <= rc;
		i_reason_code <= rs;
		i_csum_seed   <= sd;
		@(posedge i_ref_clk);
		sink_clear  <= 1'b0;
		i_req_valid <= 1'b0;
		#1 check(o_req_ready, 0);
		check(o_resp_type, 8'h96);
		// Config change mid-frame must not leak into the bytes
		if (midwr)
			wr(8'h04, 32'h1);
		k = 0;
		while (cap_count != 6'h24 && k < 400)
		begin
			@(posedge i_ref_clk);
			#1 k++;
		end
		check(o_tx_valid, 0);
		check(o_req_ready, 1);
		for (k = 0; k < 36; k++)
			check(cap_bytes[k], ew[k/4][31-8*(k%4) -: 8]);
		check(cap_last_at, 35);
		check(cap_last_cnt, 1);
		rd(8'h00, rdv);
		check(rdv, 32'h4);
		wr(8'h00, 32'h4);
	endtask : frame

	// Counts, verdict and end of run
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// Clock, watchdog and sequence
	// ----------------------------------------
	initial
	begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge i_ref_clk);
		n_fail++;
		finish_test();
	end

	initial
	begin
		{i_reset_n, i_wr_en, i_rd_en, i_req_valid} = 4'h0;
		{sink_slow, sink_clear, i_addr, i_wdata} = '0;
		{i_resp_code, i_reason_code, i_csum_seed} = '0;
		n_fail    = 0;
		cmp_count = 0;
		repeat (2) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		// Table of register cases, limits and reserved bits included
		foreach (rows[i])
		begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rdv);
			check(rdv, rows[i].e);
		end
		// Fast sink, then stalling sink with a mid-frame write
		frame(1'b0, 1'b0, 16'h0000, 16'h0000, 32'h00008000);
		frame(1'b1, 1'b1, 16'h0001, 16'h0002, 32'hffff0001);
		// Reset in mid-run brings back the reset values
		@(posedge i_ref_clk);
		i_reset_n <= 1'b0;
		@(posedge i_ref_clk);
		#1 check(o_resp_type, 8'h00);
		check(o_req_ready, 1);
		i_reset_n <= 1'b1;
		rd(8'h18, rdv);
		check(rdv, 32'h1);
		rd(8'h1c, rdv);
		check(rdv, 32'h100);
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
